/* pwct_pkg.sv */
// Purpose: Shared constants for the pulse width capture timer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register offsets are byte addresses.
package pwct_pkg;
  localparam logic [7:0] OFF_CTL0 = 8'h00;
  localparam logic [7:0] OFF_OPT0 = 8'h04;
  localparam logic [7:0] OFF_IOC0 = 8'h08;
  localparam logic [7:0] OFF_IOC1 = 8'h0c;
  localparam logic [7:0] OFF_CCR0 = 8'h10;
  localparam logic [7:0] OFF_CCR1 = 8'h14;
  localparam logic [7:0] OFF_SEL = 8'h18;
  localparam logic [7:0] OFF_IST = 8'h1c;
  localparam logic [7:0] OFF_IMSK = 8'h20;
  localparam logic [7:0] OFF_PSC = 8'h24;
  localparam int CTL_CE = 7;
  localparam int MD_LO = 0;
  localparam int OPT_OVF = 0;
  localparam int SEL_IN1 = 4;
  localparam int SEL_IN0 = 3;
  localparam logic [7:0] SEL_MASK = 8'h18;
  localparam int IOC_OE0 = 0;
  localparam int IOC_OL0 = 1;
  localparam int IOC_OE1 = 2;
  localparam int IOC_OL1 = 3;
  localparam int IST_CC0 = 0;
  localparam int IST_CC1 = 1;
  localparam int IST_OV = 2;
  localparam logic [2:0] MODE_PWM_MEAS = 3'b110;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_STOP = 16'hffff;
  localparam logic [1:0] EDGE_NONE = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  localparam int PSC_W = 10;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

/* pwct_edge.sv */
// Purpose: Valid edge detector for one capture input.
// Assumes: Input already synchronous to sys_clk.
// Notes: Edge selection of none never fires.
module pwct_edge
  import pwct_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sig_in,
  input wire logic [1:0] edge_sel,
  output logic hit
);
  typedef struct packed {
    logic prev;
  } pwct_edge_st_t;
  pwct_edge_st_t st_ff;
  pwct_edge_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.prev = sig_in;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  always_comb
  begin
    unique case (edge_sel)
      EDGE_NONE: hit = 1'b0;
      EDGE_RISE: hit = sig_in & ~st_ff.prev;
      EDGE_FALL: hit = ~sig_in & st_ff.prev;
      EDGE_BOTH: hit = sig_in ^ st_ff.prev;
    endcase
  end
endmodule

/* pwct_top.sv */
// Purpose: 16-bit timer channel with pulse width measurement, output pins, input routing.
// Assumes: APB slave on sys_clk; capture and serial lines synchronous to sys_clk.
// Notes: Count clock is a one-cycle enable from a prescaler or an external event.
module pwct_top
  import pwct_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_zero,
  input wire logic capture_input_one,
  input wire logic serial_receive_line0,
  input wire logic serial_receive_line1,
  input wire logic ext_event,
  output logic timer_output_zero,
  output logic timer_output_one,
  output logic irq,
  output logic capture_irq0,
  output logic capture_irq1,
  output logic overflow_irq
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] opt0;
    logic [7:0] ioc0;
    logic [7:0] ioc1;
    logic [7:0] sel;
    logic [2:0] ist;
    logic [2:0] imsk;
    logic [7:0] psc_sel;
    logic [PSC_W-1:0] psc_cnt;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ccr0;
    logic [CNT_W-1:0] ccr1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic to0;
    logic to1;
    logic irq;
    logic cc0p;
    logic cc1p;
    logic ovp;
    logic ext_prev;
    logic primed;
  } pwct_st_t;

  pwct_st_t st_ff;
  pwct_st_t nxt_st;
  logic src0;
  logic src1;
  logic hit0;
  logic hit1;

  // Set wins over clear for every sticky flag.
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // Pin level: inactive level is the level bit, active level its inverse.
  function automatic logic pin_lvl(input logic ol, input logic oe, input logic run);
    pin_lvl = (oe & run) ? ~ol : ol;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  assign src0 = st_ff.sel[SEL_IN0] ? serial_receive_line0 : capture_input_zero;
  assign src1 = st_ff.sel[SEL_IN1] ? serial_receive_line1 : capture_input_one;

  pwct_edge u_edge0 (
    .sys_clk(sys_clk),
    .rst(rst),
    .sig_in(src0),
    .edge_sel(st_ff.ioc1[1:0]),
    .hit(hit0)
  );

  pwct_edge u_edge1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .sig_in(src1),
    .edge_sel(st_ff.ioc1[3:2]),
    .hit(hit1)
  );

  ////////////////////////////////////////////////////////////////////////////////
  logic run;
  logic meas;
  logic tick;
  logic cap0;
  logic cap1;
  logic ovf;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic [2:0] ist_set;
  logic [2:0] ist_clr;
  logic ovf_clr;
  logic [31:0] rdv;
  logic map_ok;
  logic [PSC_W-1:0] psc_mask;

  always_comb
  begin
    nxt_st = st_ff;
    run = st_ff.ctl0[CTL_CE];
    meas = (st_ff.ctl0[MD_LO +: 3] == MODE_PWM_MEAS);
    psc_mask = PSC_W'((1 << st_ff.psc_sel[3:0]) - 1);
    if (st_ff.psc_sel[3:0] == 4'hf)
    begin
      tick = ext_event & ~st_ff.ext_prev;
    end
    else
    begin
      tick = ((st_ff.psc_cnt & psc_mask) == '0);
    end
    cap0 = run & meas & hit0;
    cap1 = run & meas & hit1;
    ovf = run & meas & tick & ~cap0 & ~cap1 & st_ff.primed & (st_ff.cnt == CNT_MAX);
    wr = psel & penable & pwrite;
    rd = psel & penable & ~pwrite;
    wb = pwdata[7:0];
    nxt_st.psc_cnt = run ? PSC_W'(st_ff.psc_cnt + 1'b1) : '0;
    nxt_st.ext_prev = ext_event;
    // The first count clock after a start moves the stopped value FFFFH to zero.
    // That step is a start, not an overflow, so overflow waits until the counter has moved.
    nxt_st.primed = run & (st_ff.primed | tick | cap0 | cap1);
    // Counter and captures.
    if (!run)
    begin
      nxt_st.cnt = CNT_STOP;
    end
    else if (cap0 | cap1)
    begin
      nxt_st.cnt = CNT_ZERO;
    end
    else if (tick)
    begin
      nxt_st.cnt = CNT_W'(st_ff.cnt + 1'b1);
    end
    if (cap0)
    begin
      nxt_st.ccr0 = st_ff.cnt;
    end
    if (cap1)
    begin
      nxt_st.ccr1 = st_ff.cnt;
    end
    nxt_st.cc0p = cap0;
    nxt_st.cc1p = cap1;
    nxt_st.ovp = ovf;
    // Register writes.
    ovf_clr = 1'b0;
    ist_clr = '0;
    if (wr)
    begin
      unique case (paddr)
        OFF_CTL0: nxt_st.ctl0 = wb;
        OFF_OPT0: ovf_clr = ~wb[OPT_OVF];
        OFF_IOC0: nxt_st.ioc0 = wb;
        OFF_IOC1: nxt_st.ioc1 = wb;
        OFF_SEL: nxt_st.sel = wb & SEL_MASK;
        OFF_IST: ist_clr = wb[2:0];
        OFF_IMSK: nxt_st.imsk = wb[2:0];
        OFF_PSC: nxt_st.psc_sel = wb;
        default: nxt_st.ctl0 = st_ff.ctl0;
      endcase
    end
    nxt_st.opt0 = '0;
    nxt_st.opt0[OPT_OVF] = sticky(st_ff.opt0[OPT_OVF], ovf, ovf_clr);
    ist_set = {ovf, cap1, cap0};
    for (int i = 0; i < 3; i++)
    begin
      nxt_st.ist[i] = sticky(st_ff.ist[i], ist_set[i], ist_clr[i]);
    end
    nxt_st.irq = |(nxt_st.ist & nxt_st.imsk);
    // Read mux.
    map_ok = 1'b1;
    rdv = RD_ZERO;
    unique case (paddr)
      OFF_CTL0: rdv[7:0] = st_ff.ctl0;
      OFF_OPT0: rdv[7:0] = st_ff.opt0;
      OFF_IOC0: rdv[7:0] = st_ff.ioc0;
      OFF_IOC1: rdv[7:0] = st_ff.ioc1;
      OFF_CCR0: rdv[CNT_W-1:0] = st_ff.ccr0;
      OFF_CCR1: rdv[CNT_W-1:0] = st_ff.ccr1;
      OFF_SEL: rdv[7:0] = st_ff.sel;
      OFF_IST: rdv[2:0] = st_ff.ist;
      OFF_IMSK: rdv[2:0] = st_ff.imsk;
      OFF_PSC: rdv[7:0] = st_ff.psc_sel;
      default: map_ok = 1'b0;
    endcase
    nxt_st.pready = psel & ~penable;
    nxt_st.pslverr = psel & ~penable & ~map_ok;
    nxt_st.prdata = (psel & ~penable & ~pwrite) ? rdv : RD_ZERO;
    // Output pins: measurement mode has no waveform, only the static level control.
    nxt_st.to0 = pin_lvl(nxt_st.ioc0[IOC_OL0], nxt_st.ioc0[IOC_OE0],
                         nxt_st.ctl0[CTL_CE]);
    nxt_st.to1 = pin_lvl(nxt_st.ioc0[IOC_OL1], nxt_st.ioc0[IOC_OE1],
                         nxt_st.ctl0[CTL_CE]);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.cnt <= CNT_STOP;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign timer_output_zero = st_ff.to0;
  assign timer_output_one = st_ff.to1;
  assign irq = st_ff.irq;
  assign capture_irq0 = st_ff.cc0p;
  assign capture_irq1 = st_ff.cc1p;
  assign overflow_irq = st_ff.ovp;

  ////////////////////////////////////////////////////////////////////////////////
  capture_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    cap0 |=> (st_ff.cnt == CNT_ZERO) && capture_irq0 && (st_ff.ccr0 == $past(st_ff.cnt)))
    else $error("capture did not store and clear");
  capture_one_a: assert property (@(posedge sys_clk) disable iff (rst)
    cap1 |=> (st_ff.cnt == CNT_ZERO) && capture_irq1 && (st_ff.ccr1 == $past(st_ff.cnt)))
    else $error("second capture did not store and clear");
  wrap_ovf_a: assert property (@(posedge sys_clk) disable iff (rst)
    (run && meas && tick && !cap0 && !cap1 && st_ff.primed && st_ff.cnt == CNT_MAX)
      |=> overflow_irq && st_ff.cnt == CNT_ZERO)
    else $error("overflow did not wrap");
  start_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    (run && tick && !cap0 && !cap1 && !st_ff.primed)
      |=> st_ff.cnt == CNT_ZERO && !overflow_irq)
    else $error("start counted as overflow");
  stop_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !run |=> st_ff.cnt == CNT_STOP)
    else $error("stopped counter moved");
  ovf_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(overflow_irq) |-> st_ff.opt0[OPT_OVF])
    else $error("overflow flag not set");
  ovf_status_a: assert property (@(posedge sys_clk) disable iff (rst)
    overflow_irq |-> st_ff.ist[IST_OV])
    else $error("overflow status not set");
  ovf_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    overflow_irq |=> !overflow_irq)
    else $error("overflow request longer than one cycle");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && paddr == OFF_OPT0 && !pwdata[OPT_OVF] && !ovf) |=> !st_ff.opt0[OPT_OVF])
    else $error("overflow flag not cleared");
  flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_ff.opt0[OPT_OVF] && !(wr && paddr == OFF_OPT0)) |=> st_ff.opt0[OPT_OVF])
    else $error("overflow flag dropped by hardware");
  count_up_a: assert property (@(posedge sys_clk) disable iff (rst)
    (run && meas && tick && !cap0 && !cap1 && st_ff.cnt != CNT_MAX)
      |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
    else $error("counter did not count");
  pin_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && paddr == OFF_IOC0 && !run) |=> timer_output_one == $past(pwdata[IOC_OL1]))
    else $error("stopped pin not at its level bit");
  pin_active_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && paddr == OFF_IOC0 && run)
      |=> timer_output_zero == ($past(pwdata[IOC_OL0]) ^ $past(pwdata[IOC_OE0])))
    else $error("running pin level wrong");
  sel_bits_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_ff.sel & ~SEL_MASK) == 8'h00)
    else $error("select reserved bits set");
  sel_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && paddr == OFF_SEL) |=> st_ff.sel[SEL_IN1] == $past(pwdata[SEL_IN1])
      && st_ff.sel[SEL_IN0] == $past(pwdata[SEL_IN0]))
    else $error("select bit not stored");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    (capture_irq0 && st_ff.imsk[IST_CC0]) |-> irq)
    else $error("capture request not signalled");
  stop_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    !meas |=> !capture_irq0 && !capture_irq1 && !overflow_irq)
    else $error("event outside measurement mode");
endmodule

/* pwct_src.sv */
// Purpose: Model of the pulse sources that drive the capture and receive lines.
// Assumes: The bench asks for a pulse by raising one bit of fire for a cycle.
// Notes: Lines are driven at all times, so there is no released state to model.
module pwct_src
(
  input wire logic sys_clk,
  input wire logic [3:0] fire,
  output logic [3:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // Capture pins idle low; receive lines idle high, as a serial line does.
  localparam logic [3:0] IDLE = 4'hc;
  always_ff @(posedge sys_clk)
  begin
    lines <= IDLE ^ fire;
  end
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the pulse width capture timer.
// Assumes: Zero wait state APB slave; prescaler set to tick every cycle.
// Notes: The external event count clock is driven in the last test; slow prescalers go untested.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pwct_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err, ext;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] fire, lines;
  logic to0, to1, irq, ci0, ci1, ovi;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_ci0 = 0;
  int n_ci1 = 0;
  int n_ovi = 0;
  pwct_top pwct_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input_zero(lines[0]), .capture_input_one(lines[1]),
    .serial_receive_line0(lines[2]), .serial_receive_line1(lines[3]), .ext_event(ext),
    .timer_output_zero(to0), .timer_output_one(to1), .irq(irq), .capture_irq0(ci0),
    .capture_irq1(ci1), .overflow_irq(ovi));
  pwct_src pwct_src_i (.sys_clk(sys_clk), .fire(fire), .lines(lines));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // The whole run needs about 66000 cycles; the ceiling leaves a margin.
  // Event requests stand one cycle each; they are counted at the edge after they rise.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (ci0 === 1'b1)
      n_ci0++;
    if (ci1 === 1'b1)
      n_ci1++;
    if (ovi === 1'b1)
      n_ovi++;
    if (cyc == 90000)
    begin
      num_errors++;
      conclude();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge sys_clk);
    fire <= m;
    @(posedge sys_clk);
    fire <= 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, fire, ext} = '0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk("sel_reset", OFF_SEL, 32'h0);
    xfer(1'b1, OFF_SEL, 32'hff);
    rdchk("sel_fixed_bits", OFF_SEL, 32'h18);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    xfer(1'b1, OFF_SEL, 32'h0);
    $display("test registers done");
    xfer(1'b1, OFF_PSC, 32'h0);
    xfer(1'b1, OFF_IOC1, 32'h1);
    xfer(1'b1, OFF_IMSK, 32'h7);
    xfer(1'b1, OFF_CTL0, 32'h86);
    pulse(4'h1);
    repeat (40) @(posedge sys_clk);
    pulse(4'h1);
    repeat (4) @(posedge sys_clk);
    // Second edge comes 42 cycles after the first; count restarts at zero.
    rdchk("capture_value", OFF_CCR0, 32'h29);
    rdchk("capture_status", OFF_IST, 32'h1);
    chk("irq_on", 32'h1, {31'h0, irq});
    xfer(1'b1, OFF_IST, 32'h7);
    repeat (2) @(posedge sys_clk);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("test capture done");
    repeat (65000) @(posedge sys_clk);
    rdchk("no_overflow_yet", OFF_OPT0, 32'h0);
    repeat (600) @(posedge sys_clk);
    rdchk("overflow_flag", OFF_OPT0, 32'h1);
    rdchk("overflow_status", OFF_IST, 32'h4);
    pulse(4'h1);
    repeat (4) @(posedge sys_clk);
    rdchk("flag_kept", OFF_OPT0, 32'h1);
    xfer(1'b1, OFF_OPT0, 32'h1);
    rdchk("flag_write_one", OFF_OPT0, 32'h1);
    xfer(1'b1, OFF_OPT0, 32'h0);
    rdchk("flag_cleared", OFF_OPT0, 32'h0);
    $display("test overflow done");
    xfer(1'b1, OFF_CTL0, 32'h0);
    xfer(1'b1, OFF_IOC1, 32'h3);
    xfer(1'b1, OFF_SEL, 32'h8);
    xfer(1'b1, OFF_IST, 32'h7);
    xfer(1'b1, OFF_CTL0, 32'h86);
    pulse(4'h1);
    repeat (4) @(posedge sys_clk);
    rdchk("pin_ignored", OFF_IST, 32'h0);
    pulse(4'h4);
    repeat (4) @(posedge sys_clk);
    rdchk("serial_routed", OFF_IST, 32'h1);
    xfer(1'b1, OFF_CTL0, 32'h0);
    xfer(1'b1, OFF_IOC1, 32'h4);
    xfer(1'b1, OFF_SEL, 32'h10);
    xfer(1'b1, OFF_IST, 32'h7);
    xfer(1'b1, OFF_CTL0, 32'h86);
    pulse(4'h2);
    repeat (4) @(posedge sys_clk);
    rdchk("pin1_ignored", OFF_IST, 32'h0);
    pulse(4'h8);
    repeat (4) @(posedge sys_clk);
    rdchk("serial1_routed", OFF_IST, 32'h2);
    $display("test selector done");
    xfer(1'b1, OFF_CTL0, 32'h0);
    xfer(1'b1, OFF_IOC0, 32'hd);
    repeat (2) @(posedge sys_clk);
    chk("out0_stopped", 32'h0, {31'h0, to0});
    chk("out1_stopped", 32'h1, {31'h0, to1});
    xfer(1'b1, OFF_CTL0, 32'h86);
    repeat (2) @(posedge sys_clk);
    chk("out0_counting", 32'h1, {31'h0, to0});
    chk("out1_counting", 32'h0, {31'h0, to1});
    xfer(1'b1, OFF_IOC0, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk("out1_disabled", 32'h1, {31'h0, to1});
    $display("test outputs done");
    xfer(1'b1, OFF_CTL0, 32'h0);
    xfer(1'b1, OFF_IOC1, 32'h2);
    xfer(1'b1, OFF_SEL, 32'h8);
    xfer(1'b1, OFF_PSC, 32'hf);
    xfer(1'b1, OFF_CTL0, 32'h86);
    // Events come before any trigger, so no capture falls right after the start.
    repeat (5)
    begin
      @(posedge sys_clk);
      ext <= 1'b1;
      @(posedge sys_clk);
      ext <= 1'b0;
    end
    pulse(4'h4);
    repeat (4) @(posedge sys_clk);
    // The first event moves the stopped count to zero, the next four count it up.
    rdchk("event_count", OFF_CCR0, 32'h4);
    chk("cap0_pulses", 32'h6, n_ci0);
    chk("cap1_pulses", 32'h1, n_ci1);
    chk("ovf_pulses", 32'h1, n_ovi);
    $display("test event count done");
    conclude();
  end
endmodule
